// ### core/hspb_home_search.sv
// Position and speed biasing with orientation home search sequencing.
`timescale 1ns/100ps
module hspb_home_search #(
  parameter int TICK_CYCLES = hspb_pkg::TICK_CYCLES_DFLT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hspb_pkg::hspb_cfg_t cfg,
  input wire hspb_pkg::hspb_enc_t enc,
  input wire logic runCmd,
  input wire logic pulseTrainMode,
  input wire logic signed [15:0] speedCmd,
  input wire logic signed [15:0] positionCmdDelta,
  input wire logic [hspb_pkg::NUM_IN-1:0] inputTerminalLevel,
  input wire logic [hspb_pkg::NUM_IN*7-1:0] inputTerminalFunctionSelect,
  input wire logic [hspb_pkg::NUM_OUT*7-1:0] outputTerminalFunctionSelect,
  output logic signed [15:0] frequencyCmd,
  output logic signed [17:0] positionDelta,
  output logic tickPulse,
  output logic positionControl,
  output logic servoLock,
  output logic positioningEndOutput,
  output logic [hspb_pkg::NUM_OUT-1:0] outputTerminal,
  output logic alarmRelay
);
  import hspb_pkg::*;

  typedef struct packed {
    hspb_mode_t mode;
    logic [17:0] tickCnt;
    logic tick;
    logic signed [15:0] freq;
    logic signed [17:0] posDelta;
    logic [17:0] remaining;
    logic [12:0] delayCnt;
    logic positioning_end_output;
    logic zPrev;
    logic ortPrev;
    logic [NUM_OUT-1:0] outTerm;
    logic relay;
  } hspb_state_t;

  hspb_state_t s_q;
  hspb_state_t s_d;

  logic [15:0] pprEff;
  logic [15:0] stopPulses;
  logic [17:0] speedEff;
  logic [17:0] rangeEff;
  logic [17:0] gainEff;
  logic orientationInput;
  logic addActive;
  logic zLevel;
  logic zRise;
  logic reverseDir;
  logic signed [15:0] normalTarget;
  logic signed [15:0] searchTarget;
  logic signed [15:0] rampTarget;
  logic [35:0] gainProduct;
  logic [35:0] gainFreq;
  logic [17:0] posFreq;
  logic [17:0] target;
  logic [12:0] delayTicks;

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES > 262143) begin
      $error("hspb_home_search: TICK_CYCLES out of range");
    end
  end

  function automatic logic [17:0] clampMax(input logic [17:0] v, input logic [17:0] lim);
    clampMax = (v > lim) ? lim : v;
  endfunction

  function automatic logic anyCode(input logic [NUM_IN-1:0] lvl,
                                   input logic [NUM_IN*7-1:0] sel,
                                   input logic [6:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (lvl[i] && sel[i*7 +: 7] == code) begin
        hit = 1'b1;
      end
    end
    anyCode = hit;
  endfunction

  // Moves the frequency one step per tick toward its target.
  function automatic logic signed [15:0] rampTo(input logic signed [15:0] cur,
                                                input logic signed [15:0] tgt,
                                                input logic [15:0] step);
    logic signed [17:0] up;
    logic signed [17:0] dn;
    up = 18'(cur) + 18'(signed'({1'b0, step}));
    dn = 18'(cur) - 18'(signed'({1'b0, step}));
    if (cur < tgt) begin
      rampTo = (up > 18'(tgt)) ? tgt : up[15:0];
    end else if (cur > tgt) begin
      rampTo = (dn < 18'(tgt)) ? tgt : dn[15:0];
    end else begin
      rampTo = cur;
    end
  endfunction

  hspb_stop_scaler #(
    .PPR_W(16)
  ) u_scaler (
    .mclk(mclk),
    .rst(rst),
    .stopPoint(cfg.homeStopPosition),
    .ppr(pprEff),
    .stopPulses(stopPulses)
  );

  always_comb begin
    // Settings below the least resolution are raised to it.
    pprEff = ({2'h0, cfg.encoderPulsesPerRev} < PPR_MIN) ? PPR_MIN[15:0]
             : cfg.encoderPulsesPerRev;
    speedEff = clampMax({2'h0, cfg.homeSearchSpeed}, SPEED_MAX);
    rangeEff = clampMax({4'h0, cfg.homeCompletionRange}, RANGE_MAX);
    gainEff = clampMax({2'h0, cfg.positionLoopGain}, GAIN_MAX);
    orientationInput = anyCode(inputTerminalLevel, inputTerminalFunctionSelect, FN_ORT);
    addActive = anyCode(inputTerminalLevel, inputTerminalFunctionSelect, FN_ADD);
    zLevel = enc.encoderRefPulsePos && !enc.encoderRefPulseNeg;
    zRise = zLevel && !s_q.zPrev;
    reverseDir = (cfg.homeSearchDirection == DIR_REV);
    delayTicks = 13'(cfg.homeCompletionDelay * DELAY_TICKS_PER_UNIT);
  end

  always_comb begin
    normalTarget = speedCmd;
    if (pulseTrainMode && addActive) begin
      if (cfg.additionalFrequencySign) begin
        normalTarget = speedCmd - signed'(cfg.additionalFrequencyAmount);
      end else begin
        normalTarget = speedCmd + signed'(cfg.additionalFrequencyAmount);
      end
    end
    searchTarget = reverseDir ? -signed'(speedEff[15:0]) : signed'(speedEff[15:0]);
    // Position loop: frequency in 0.01 Hz is gain times error over resolution.
    gainProduct = gainEff * s_q.remaining;
    gainFreq = gainProduct / {20'h0, pprEff};
    posFreq = (gainFreq > {18'h0, speedEff}) ? speedEff : gainFreq[17:0];
    // Forward stops one turn past the stop point, reverse two turns.
    target = reverseDir ? 18'({pprEff, 1'b0}) + 18'(stopPulses)
             : 18'(pprEff) + 18'(stopPulses);
    rampTarget = (s_q.mode == HS_IDLE) ? normalTarget : searchTarget;
  end

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.zPrev = zLevel;
    s_d.ortPrev = orientationInput;
    if (s_q.tickCnt == 18'(TICK_CYCLES - 1)) begin
      s_d.tickCnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tickCnt = s_q.tickCnt + 18'h1;
    end

    if (s_q.tick) begin
      if (pulseTrainMode) begin
        s_d.posDelta = 18'(positionCmdDelta) + 18'(cfg.positionBiasQuantity);
      end else begin
        s_d.posDelta = 18'(positionCmdDelta);
      end
    end

    if (s_q.mode == HS_POSITION && enc.countStep && s_q.remaining != '0) begin
      s_d.remaining = s_q.remaining - 18'h1;
    end

    case (s_q.mode)
      HS_IDLE: begin
        if (s_q.tick) begin
          s_d.freq = runCmd ? rampTo(s_q.freq, rampTarget, cfg.accelStep) : '0;
        end
        if (runCmd && orientationInput) begin
          s_d.mode = HS_ACCEL;
        end
      end
      HS_ACCEL: begin
        if (s_q.tick) begin
          s_d.freq = rampTo(s_q.freq, rampTarget, cfg.accelStep);
        end
        if (!runCmd || !orientationInput) begin
          s_d.mode = HS_IDLE;
        end else if (s_q.freq == searchTarget) begin
          s_d.mode = HS_WAITZ;
        end
      end
      HS_WAITZ: begin
        if (!runCmd || !orientationInput) begin
          s_d.mode = HS_IDLE;
        end else if (zRise) begin
          s_d.mode = HS_POSITION;
          s_d.remaining = target;
          s_d.delayCnt = '0;
        end
      end
      HS_POSITION: begin
        if (s_q.tick) begin
          s_d.freq = reverseDir ? -signed'(posFreq[15:0]) : signed'(posFreq[15:0]);
          if (s_q.remaining <= rangeEff) begin
            if (s_q.delayCnt >= delayTicks) begin
              s_d.positioning_end_output = 1'b1;
              s_d.mode = HS_LOCK;
              s_d.freq = '0;
            end else begin
              s_d.delayCnt = s_q.delayCnt + 13'h1;
            end
          end else begin
            s_d.delayCnt = '0;
          end
        end
        if (!runCmd) begin
          s_d.mode = HS_IDLE;
          s_d.freq = '0;
        end
      end
      HS_LOCK: begin
        s_d.freq = '0;
        if (!runCmd) begin
          s_d.mode = HS_IDLE;
        end
      end
      default: begin
        s_d.mode = HS_IDLE;
      end
    endcase

    if (!orientationInput) begin
      s_d.positioning_end_output = 1'b0;
    end

    for (int i = 0; i < NUM_OUT; i++) begin
      s_d.outTerm[i] = s_d.positioning_end_output && (outputTerminalFunctionSelect[i*7 +: 7] == FN_POK);
    end
    s_d.relay = s_d.positioning_end_output && (cfg.alarmRelayFunctionSelect == FN_POK);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{mode: HS_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    frequencyCmd = s_q.freq;
    positionDelta = s_q.posDelta;
    tickPulse = s_q.tick;
    positionControl = (s_q.mode == HS_POSITION) || (s_q.mode == HS_LOCK);
    servoLock = (s_q.mode == HS_LOCK);
    positioningEndOutput = s_q.positioning_end_output;
    outputTerminal = s_q.outTerm;
    alarmRelay = s_q.relay;
  end
endmodule // hspb_home_search

// ### core/hspb_pkg.sv
// Shared constants and carrier types for the home search and biasing block.
package hspb_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int TICK_TIME_US = 2000;
  localparam int TICK_CYCLES_DFLT = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int DELAY_UNIT_US = 10000;
  localparam int DELAY_TICKS_PER_UNIT = DELAY_UNIT_US / TICK_TIME_US;
  localparam int STOP_LOG2 = 12;
  localparam logic [11:0] STOP_MAX = 12'hfff;
  localparam logic [17:0] PPR_MIN = 18'h00080;
  localparam logic [17:0] SPEED_MAX = 18'h02ee0;
  localparam logic [17:0] RANGE_MAX = 18'h02710;
  localparam logic [17:0] GAIN_MAX = 18'h02710;
  localparam logic [6:0] FN_POK = 7'h17;
  localparam logic [6:0] FN_ORT = 7'h2d;
  localparam logic [6:0] FN_ADD = 7'h32;
  localparam logic [1:0] DIR_FWD = 2'h0;
  localparam logic [1:0] DIR_REV = 2'h1;
  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 5;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_ACCEL,
    HS_WAITZ,
    HS_POSITION,
    HS_LOCK
  } hspb_mode_t;

  // Settings as the operator enters them, in their printed units.
  typedef struct packed {
    logic [15:0] encoderPulsesPerRev;
    logic [11:0] homeStopPosition;
    logic [15:0] homeSearchSpeed;
    logic [1:0] homeSearchDirection;
    logic [13:0] homeCompletionRange;
    logic [9:0] homeCompletionDelay;
    logic [15:0] positionLoopGain;
    logic signed [15:0] positionBiasQuantity;
    logic [15:0] additionalFrequencyAmount;
    logic additionalFrequencySign;
    logic [15:0] accelStep;
    logic [6:0] alarmRelayFunctionSelect;
  } hspb_cfg_t;

  // Encoder events, already decoded to one-cycle pulses and levels.
  typedef struct packed {
    logic countStep;
    logic encoderRefPulsePos;
    logic encoderRefPulseNeg;
  } hspb_enc_t;
endpackage

// ### core/hspb_stop_scaler.sv
// Registered scaling of a stop point into encoder pulses past the reference.
`timescale 1ns/100ps
module hspb_stop_scaler #(
  parameter int PPR_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] stopPoint,
  input wire logic [PPR_W-1:0] ppr,
  output logic [PPR_W-1:0] stopPulses
);
  import hspb_pkg::*;

  logic [PPR_W+11:0] product;

  initial begin
    if (PPR_W < 8 || PPR_W > 24) begin
      $error("hspb_stop_scaler: PPR_W out of range");
    end
  end

  // One revolution is 4096 stop points whatever the encoder resolution.
  always_comb begin
    product = stopPoint * ppr;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stopPulses <= '0;
    end else begin
      stopPulses <= product[PPR_W+11:STOP_LOG2];
    end
  end
endmodule // hspb_stop_scaler

// ### bench/hspb_enc_model.sv
// Encoder model: count steps while the drive turns and one reference pulse per turn.
`timescale 1ns/100ps
module hspb_enc_model #(
  parameter int PPR = 128
) (
  input logic mclk,
  input logic rst,
  input logic signed [15:0] frequencyCmd,
  output hspb_pkg::hspb_enc_t enc
);
  import hspb_pkg::*;
  logic [2:0] div;
  logic [15:0] pos;
  wire step = frequencyCmd != 16'sh0 && div == 3'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      pos <= 16'h0;
      enc <= '0;
    end else begin
      div <= div + 3'h1;
      enc.countStep <= step;
      if (step)
        pos <= (pos == 16'(PPR - 1)) ? 16'h0 : pos + 16'h1;
      enc.encoderRefPulsePos <= pos == 16'h0;
      enc.encoderRefPulseNeg <= pos != 16'h0;
    end
  end
endmodule // hspb_enc_model

// ### bench/hspb_home_search_sva.sv
// Concurrent checks on the home search and biasing block ports.
`timescale 1ns/100ps
module hspb_home_search_chk #(
  parameter int TICK_CYCLES = 20
) (
  input logic mclk,
  input logic rst,
  input hspb_pkg::hspb_cfg_t cfg,
  input hspb_pkg::hspb_enc_t enc,
  input logic runCmd,
  input logic pulseTrainMode,
  input logic signed [15:0] positionCmdDelta,
  input logic [7:0] inputTerminalLevel,
  input logic [55:0] inputTerminalFunctionSelect,
  input logic signed [17:0] positionDelta,
  input logic tickPulse,
  input logic positionControl,
  input logic servoLock,
  input logic positioningEndOutput,
  input logic alarmRelay
);
  import hspb_pkg::*;
  logic ortOn;
  logic seen;
  logic [31:0] cnt;
  logic [17:0] expDelta;
  wire zL = enc.encoderRefPulsePos && !enc.encoderRefPulseNeg;
  always_comb begin
    ortOn = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      ortOn |= inputTerminalLevel[i] && inputTerminalFunctionSelect[i*7+:7] == FN_ORT;
    end
    expDelta = 18'(positionCmdDelta);
    if (pulseTrainMode)
      expDelta = expDelta + 18'(cfg.positionBiasQuantity);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h0;
      seen <= 1'b0;
    end else begin
      cnt <= tickPulse ? 32'h0 : cnt + 32'h1;
      seen <= seen | tickPulse;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff rst;
  sequence s_endRise; $rose(positioningEndOutput); endsequence
  property p_tickPeriod; tickPulse && seen |-> cnt == TICK_CYCLES - 1; endproperty
  a_tickPeriod: assert property (p_tickPeriod) else $error("tick spacing");
  property p_posDelta; tickPulse |=> positionDelta == $past(expDelta); endproperty
  a_posDelta: assert property (p_posDelta) else $error("position delta");
  property p_deltaOnTick; $changed(positionDelta) |-> $past(tickPulse); endproperty
  a_deltaOnTick: assert property (p_deltaOnTick) else $error("delta off tick");
  property p_zSwitch; $rose(positionControl) |-> $past(zL) && !$past(zL, 2); endproperty
  a_zSwitch: assert property (p_zSwitch) else $error("position start");
  property p_pokDrop; !ortOn |=> !positioningEndOutput; endproperty
  a_pokDrop: assert property (p_pokDrop) else $error("end not cleared");
  property p_pokHold; positioningEndOutput && ortOn |=> positioningEndOutput; endproperty
  a_pokHold: assert property (p_pokHold) else $error("end dropped");
  property p_lockHold; servoLock && runCmd |=> servoLock; endproperty
  a_lockHold: assert property (p_lockHold) else $error("lock dropped");
  property p_endCause;
    s_endRise |-> servoLock && alarmRelay == (cfg.alarmRelayFunctionSelect == FN_POK);
  endproperty
  a_endCause: assert property (p_endCause) else $error("end outputs");
endmodule // hspb_home_search_chk

bind hspb_home_search hspb_home_search_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// ### bench/tb.sv
// Self-checking bench for the home search and biasing block.
`timescale 1ns/100ps
module tb;
  import hspb_pkg::*;
  localparam int TC = 20;
  localparam int PPR = 128;
  hspb_cfg_t cfg;
  hspb_enc_t enc;
  logic mclk, rst, runCmd, pulseTrainMode, tickPulse, positionControl;
  logic servoLock, positioningEndOutput, alarmRelay;
  logic signed [15:0] speedCmd, positionCmdDelta, frequencyCmd, spd;
  logic signed [17:0] positionDelta;
  logic [NUM_IN-1:0] inputTerminalLevel;
  logic [NUM_IN*7-1:0] inputTerminalFunctionSelect;
  logic [NUM_OUT*7-1:0] outputTerminalFunctionSelect;
  logic [NUM_OUT-1:0] outputTerminal;
  int errors, cmpCount, steps, tgt;
  hspb_home_search #(.TICK_CYCLES(TC)) i_dut (.*);
  hspb_enc_model #(.PPR(PPR)) i_enc (.*);
  always #4 mclk = ~mclk;
  task automatic chk(string name, logic [17:0] want, logic [17:0] got);
    cmpCount++;
    if (got !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, want, got);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmpCount);
    if (errors == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic waitHi(ref logic s);
    for (int k = 0; k < 4000 && s !== 1'b1; k++)
      @(negedge mclk);
  endtask
  function automatic logic [17:0] eDelta();
    return 18'(positionCmdDelta) + (pulseTrainMode ? 18'(cfg.positionBiasQuantity) : 18'h0);
  endfunction
  function automatic logic signed [15:0] eFreq();
    if (!pulseTrainMode || !inputTerminalLevel[1])
      return speedCmd;
    return cfg.additionalFrequencySign ? speedCmd - cfg.additionalFrequencyAmount
      : speedCmd + cfg.additionalFrequencyAmount;
  endfunction
  // The limit is about eight times the expected run length.
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    cfg = '0;
    // A full-scale ramp step lets the frequency reach its target within one tick.
    cfg.accelStep = 16'hffff;
    runCmd = 1'b0;
    pulseTrainMode = 1'b0;
    speedCmd = '0;
    positionCmdDelta = '0;
    inputTerminalLevel = '0;
    inputTerminalFunctionSelect = {42'h0, FN_ADD, FN_ORT};
    outputTerminalFunctionSelect = {14'h0, FN_POK, 14'h0};
    errors = 0;
    cmpCount = 0;
    void'($urandom(32'h9023));
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    runCmd = 1'b1;
    for (int n = 0; n < 24; n++) begin
      pulseTrainMode = n < 2 ? 1'b1 : 1'($urandom);
      inputTerminalLevel = {6'h0, 1'($urandom), 1'b0};
      cfg.additionalFrequencySign = 1'($urandom);
      cfg.additionalFrequencyAmount = 16'($urandom_range(0, 2000));
      cfg.positionBiasQuantity = 16'($urandom);
      speedCmd = 16'($urandom_range(0, 9000));
      positionCmdDelta = n == 0 ? 16'sh7fff : n == 1 ? 16'sh8000 : 16'($urandom);
      if (n < 2)
        cfg.positionBiasQuantity = positionCmdDelta;
      waitHi(tickPulse);
      @(negedge mclk);
      chk("positionDelta", eDelta(), positionDelta);
      chk("frequencyCmd", 18'(eFreq()), 18'(frequencyCmd));
    end
    runCmd = 1'b0;
    pulseTrainMode = 1'b0;
    speedCmd = 16'sh0190;
    cfg.homeSearchSpeed = 16'h00c8;
    cfg.accelStep = 16'h0032;
    cfg.encoderPulsesPerRev = 16'(PPR);
    cfg.positionLoopGain = 16'h2710;
    cfg.homeCompletionRange = 14'h4;
    // Stopping first brings the frequency back to zero before each search.
    repeat (2 * TC) @(negedge mclk);
    for (int d = 0; d < 2; d++) begin
      cfg.homeSearchDirection = 2'(d);
      cfg.homeStopPosition = d ? 12'hfff : 12'($urandom);
      cfg.homeCompletionDelay = 10'(d);
      cfg.alarmRelayFunctionSelect = d ? 7'h0 : FN_POK;
      tgt = (d + 1) * PPR + int'(cfg.homeStopPosition) * PPR / 4096;
      spd = d ? -16'sd200 : 16'sd200;
      runCmd = 1'b1;
      inputTerminalLevel = {7'h0, d == 0};
      repeat (3 * TC) @(negedge mclk);
      inputTerminalLevel = 8'h01;
      for (int k = 0; k < 4000 && frequencyCmd !== spd; k++)
        @(negedge mclk);
      chk("frequencyCmd", 18'(spd), 18'(frequencyCmd));
      waitHi(positionControl);
      chk("positionControl", 18'h1, 18'(positionControl));
      steps = 0;
      for (int k = 0; k < 20000 && positioningEndOutput !== 1'b1; k++) begin
        @(negedge mclk);
        steps += enc.countStep;
      end
      chk("steps", 18'h1, 18'(steps >= tgt - 4 && steps <= tgt + 3));
      chk("servoLock", 18'h1, 18'(servoLock));
      chk("outputTerminal", 18'h4, 18'(outputTerminal));
      chk("alarmRelay", 18'(d == 0), 18'(alarmRelay));
      runCmd = 1'b0;
      repeat (2 * TC) @(negedge mclk);
      chk("servoLock", 18'h0, 18'(servoLock));
      chk("positioningEnd", 18'h1, 18'(positioningEndOutput));
      inputTerminalLevel = '0;
      repeat (2) @(negedge mclk);
      chk("positioningEnd", 18'h0, 18'(positioningEndOutput));
    end
    end_of_test();
  end
endmodule // tb
